// ---- pwp_pkg.sv ----
package pwp_pkg;

  // ------------------------------------------------------------
  // register map, one byte per address
  // ------------------------------------------------------------
  localparam int PWP_ADDR_W = 4;
  localparam logic [3:0] PWP_OFS_CNT_LO = 4'h0;
  localparam logic [3:0] PWP_OFS_CNT_HI = 4'h1;
  localparam logic [3:0] PWP_OFS_PER1_LO = 4'h2;
  localparam logic [3:0] PWP_OFS_PER1_HI = 4'h3;
  localparam logic [3:0] PWP_OFS_DUTY1_LO = 4'h4;
  localparam logic [3:0] PWP_OFS_DUTY1_HI = 4'h5;
  localparam logic [3:0] PWP_OFS_PER2_LO = 4'h6;
  localparam logic [3:0] PWP_OFS_PER2_HI = 4'h7;
  localparam logic [3:0] PWP_OFS_DUTY2_LO = 4'h8;
  localparam logic [3:0] PWP_OFS_DUTY2_HI = 4'h9;
  localparam logic [3:0] PWP_OFS_CTL0_FIRST = 4'hA;
  localparam logic [3:0] PWP_OFS_CTL1_FIRST = 4'hB;
  localparam logic [3:0] PWP_OFS_CTL2_FIRST = 4'hC;
  localparam logic [3:0] PWP_OFS_CTL0_SECOND = 4'hD;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  // first_control_zero: [2:0] clock divide select, [3] event point, [4] polarity
  localparam int PWP_C0_CLKSEL_LSB = 0;
  localparam int PWP_C0_EVPT_BIT = 3;
  localparam int PWP_C0_POL_BIT = 4;
  // second_control_zero: [0] polarity
  localparam int PWP_C0S_POL_BIT = 0;
  // first_control_one
  localparam int PWP_C1_RUN_BIT = 0;
  localparam int PWP_C1_STAT_BIT = 1;
  localparam int PWP_C1_ONESHOT_BIT = 2;
  localparam int PWP_C1_PAIR_BIT = 3;
  localparam int PWP_C1_DT_BIT = 4;
  // first_control_two: [1:0] mode, [3:2] edge select, [4] pin select
  localparam int PWP_C2_MODE_LSB = 0;
  localparam int PWP_C2_EDGE_LSB = 2;
  localparam int PWP_C2_PIN_BIT = 4;

  // ------------------------------------------------------------
  // limits and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] PWP_PERIOD_MIN = 16'h0001;
  localparam logic [15:0] PWP_PERIOD_MAX = 16'h0FFF;
  localparam logic [15:0] PWP_DUTY_MIN = 16'h0000;
  localparam logic [15:0] PWP_DUTY_MAX = 16'hFFFE;
  localparam logic [15:0] PWP_RST_COUNT = 16'h0000;
  localparam logic [15:0] PWP_RST_PERIOD = 16'h0FFF;
  localparam logic [15:0] PWP_RST_DUTY = 16'h0000;
  localparam logic [7:0] PWP_RST_CTL = 8'h00;

  // external control modes
  localparam logic [1:0] PWP_EXT_OFF = 2'h0;
  localparam logic [1:0] PWP_EXT_START = 2'h1;
  localparam logic [1:0] PWP_EXT_STOP = 2'h2;
  localparam logic [1:0] PWP_EXT_CLEAR = 2'h3;
  // trigger edge / level selections
  localparam logic [1:0] PWP_TRG_RISE = 2'h0;
  localparam logic [1:0] PWP_TRG_FALL = 2'h1;
  localparam logic [1:0] PWP_TRG_BOTH = 2'h2;
  localparam logic [1:0] PWP_TRG_HIGH = 2'h3;

endpackage

// ---- pwp_pair_pwm.sv ----
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps

// Behaviour
// - run set: status first tick, count second
// - counter equals first duty: first flag low
// - counter equals second duty: second flag low
// - repeat: period match sets flag, clears, continues
// - period match reloads all duty/period buffers
// - one-shot: period match clears counter, stops, clears run
// - run write restarts after one-shot end
// - run cleared: one more count, then halt
// - status clears when counter really halted
// - restart resumes from retained counter value
// - counter byte write clears counter, first flag high
// - stopped: register writes go straight to buffers
// - control zero selects clock, event point, polarity
// - external trigger starts, stops or clears counter
// - edge bits and pin select choose trigger
// - first period is setting plus one, clamped
// - first duty is setting plus one, clamped
// - second delay1 is duty plus one, clamped
// - second delay2 is period plus one, clamped
// - first event may be one tick late
// - dead time enable inserts both-off interval
// - pairing bit selects cooperation, one-shot bit mode
module pwp_pair_pwm
  import pwp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [PWP_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic trigger_a_i,
  input wire logic trigger_b_i,
  output logic [7:0] rdata_o,
  output logic first_pwm_output_o,
  output logic second_pwm_output_o,
  output logic pwm_event_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] div_cnt;
    logic [15:0] count;
    logic [15:0] first_period;
    logic [15:0] first_duty;
    logic [15:0] second_period;
    logic [15:0] second_duty;
    logic [15:0] first_period_buffer;
    logic [15:0] first_duty_buffer;
    logic [15:0] second_period_buffer;
    logic [15:0] second_duty_buffer;
    logic [7:0] first_control_zero;
    logic [7:0] first_control_two;
    logic [7:0] second_control_zero;
    logic run_request_bit;
    logic running_status_bit;
    logic one_shot_select;
    logic pair_cooperation_enable;
    logic dead_time_enable;
    logic first_output_flag;
    logic second_output_flag;
    logic trig_prev;
    logic out_first;
    logic out_second;
    logic event_pulse;
    logic [7:0] rdata;
  } pwp_state_type;

  pwp_state_type s;
  pwp_state_type next_s;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // clamp a setting into its legal window before it reaches a buffer
  function automatic logic [15:0] pwp_clamp(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  // replace one byte of a 16-bit register
  function automatic logic [15:0] pwp_byte(input logic [15:0] old, input logic hi,
                                           input logic [7:0] b);
    if (hi) begin
      return {b, old[7:0]};
    end
    return {old[15:8], b};
  endfunction

  // divider mask: tick when the low bits of the divider are all ones
  function automatic logic [7:0] pwp_div_mask(input logic [2:0] sel);
    case (sel)
      3'h0: return 8'h00;
      3'h1: return 8'h01;
      3'h2: return 8'h03;
      3'h3: return 8'h07;
      3'h4: return 8'h0F;
      3'h5: return 8'h1F;
      3'h6: return 8'h3F;
      default: return 8'h7F;
    endcase
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic tick;
  logic [7:0] mask;
  logic trig_now;
  logic trig_hit;
  logic [15:0] first_low_point;
  logic [15:0] second_high_point;
  logic period_match;
  logic duty_match;
  logic hi_byte;

  always_comb begin
    next_s = s;
    next_s.event_pulse = 1'b0;
    next_s.rdata = 8'h00;
    hi_byte = addr_i[0];
    period_match = 1'b0;
    duty_match = 1'b0;

    // pwm count clock: one-cycle enable pulse standing for its falling edge
    mask = pwp_div_mask(s.first_control_zero[PWP_C0_CLKSEL_LSB +: 3]);
    tick = ((s.div_cnt & mask) == mask);
    next_s.div_cnt = s.div_cnt + 8'h01;

    // dead time moves the first fall later and the second rise earlier
    if (s.dead_time_enable) begin
      first_low_point = s.first_duty_buffer + s.second_duty_buffer;
      second_high_point = s.first_duty_buffer;
    end else begin
      first_low_point = s.first_duty_buffer;
      second_high_point = s.second_period_buffer;
    end

    // counting engine; start waits for a tick, so the first cycle may be late
    if (tick) begin
      if (!s.running_status_bit) begin
        if (s.run_request_bit) begin
          next_s.running_status_bit = 1'b1;
        end
      end else begin
        if (s.count == first_low_point) begin
          next_s.first_output_flag = 1'b0;
          duty_match = 1'b1;
        end
        if (s.pair_cooperation_enable) begin
          if (s.count == s.second_duty_buffer) begin
            next_s.second_output_flag = 1'b0;
          end
          if (s.count == second_high_point) begin
            next_s.second_output_flag = 1'b1;
          end
        end else begin
          // second channel idles high while not paired
          next_s.second_output_flag = 1'b1;
        end
        if (s.count == s.first_period_buffer) begin
          period_match = 1'b1;
          next_s.first_output_flag = 1'b1;
          next_s.count = PWP_RST_COUNT;
          // reload from settings; clamping keeps the plus-one periods in range
          next_s.first_period_buffer = pwp_clamp(s.first_period, PWP_PERIOD_MIN,
                                                 PWP_PERIOD_MAX);
          next_s.first_duty_buffer = pwp_clamp(s.first_duty, PWP_DUTY_MIN,
                                               PWP_DUTY_MAX);
          next_s.second_period_buffer = pwp_clamp(s.second_period, PWP_PERIOD_MIN,
                                                  PWP_PERIOD_MAX);
          next_s.second_duty_buffer = pwp_clamp(s.second_duty, PWP_DUTY_MIN,
                                                PWP_DUTY_MAX);
          if (s.one_shot_select) begin
            next_s.run_request_bit = 1'b0;
            next_s.running_status_bit = 1'b0;
          end
        end else begin
          next_s.count = s.count + 16'h0001;
        end
        // a cleared run bit still lets this last count happen
        if (!s.run_request_bit) begin
          next_s.running_status_bit = 1'b0;
        end
      end
    end

    // event point select: period match or first duty match
    if (s.first_control_zero[PWP_C0_EVPT_BIT]) begin
      next_s.event_pulse = duty_match;
    end else begin
      next_s.event_pulse = period_match;
    end

    // external trigger: pin select, then edge or level qualifier
    trig_now = s.first_control_two[PWP_C2_PIN_BIT] ? trigger_b_i : trigger_a_i;
    next_s.trig_prev = trig_now;
    case (s.first_control_two[PWP_C2_EDGE_LSB +: 2])
      PWP_TRG_RISE: trig_hit = trig_now && !s.trig_prev;
      PWP_TRG_FALL: trig_hit = !trig_now && s.trig_prev;
      PWP_TRG_BOTH: trig_hit = trig_now != s.trig_prev;
      default: trig_hit = trig_now;
    endcase
    if (trig_hit) begin
      case (s.first_control_two[PWP_C2_MODE_LSB +: 2])
        PWP_EXT_START: next_s.run_request_bit = 1'b1;
        PWP_EXT_STOP: next_s.run_request_bit = 1'b0;
        PWP_EXT_CLEAR: begin
          next_s.count = PWP_RST_COUNT;
          next_s.first_output_flag = 1'b1;
          next_s.second_output_flag = 1'b1;
          next_s.run_request_bit = 1'b1;
        end
        default: ;
      endcase
    end

    // register writes come last so software wins a same-cycle collision
    if (wr_i) begin
      case (addr_i)
        PWP_OFS_CNT_LO, PWP_OFS_CNT_HI: begin
          next_s.count = PWP_RST_COUNT;
          next_s.first_output_flag = 1'b1;
        end
        PWP_OFS_PER1_LO, PWP_OFS_PER1_HI: begin
          next_s.first_period = pwp_byte(s.first_period, hi_byte, wdata_i);
          if (!s.run_request_bit) begin
            next_s.first_period_buffer = pwp_clamp(next_s.first_period, PWP_PERIOD_MIN,
                                                   PWP_PERIOD_MAX);
          end
        end
        PWP_OFS_DUTY1_LO, PWP_OFS_DUTY1_HI: begin
          next_s.first_duty = pwp_byte(s.first_duty, hi_byte, wdata_i);
          if (!s.run_request_bit) begin
            next_s.first_duty_buffer = pwp_clamp(next_s.first_duty, PWP_DUTY_MIN,
                                                 PWP_DUTY_MAX);
          end
        end
        PWP_OFS_PER2_LO, PWP_OFS_PER2_HI: begin
          next_s.second_period = pwp_byte(s.second_period, hi_byte, wdata_i);
          if (!s.run_request_bit) begin
            next_s.second_period_buffer = pwp_clamp(next_s.second_period, PWP_PERIOD_MIN,
                                                    PWP_PERIOD_MAX);
          end
        end
        PWP_OFS_DUTY2_LO, PWP_OFS_DUTY2_HI: begin
          next_s.second_duty = pwp_byte(s.second_duty, hi_byte, wdata_i);
          if (!s.run_request_bit) begin
            next_s.second_duty_buffer = pwp_clamp(next_s.second_duty, PWP_DUTY_MIN,
                                                  PWP_DUTY_MAX);
          end
        end
        PWP_OFS_CTL0_FIRST: next_s.first_control_zero = wdata_i;
        PWP_OFS_CTL1_FIRST: begin
          next_s.run_request_bit = wdata_i[PWP_C1_RUN_BIT];
          next_s.one_shot_select = wdata_i[PWP_C1_ONESHOT_BIT];
          next_s.pair_cooperation_enable = wdata_i[PWP_C1_PAIR_BIT];
          next_s.dead_time_enable = wdata_i[PWP_C1_DT_BIT];
        end
        PWP_OFS_CTL2_FIRST: next_s.first_control_two = wdata_i;
        PWP_OFS_CTL0_SECOND: next_s.second_control_zero = wdata_i;
        default: ;
      endcase
    end

    // read data stands only in the cycle after the strobe
    if (rd_i) begin
      case (addr_i)
        PWP_OFS_CNT_LO: next_s.rdata = s.count[7:0];
        PWP_OFS_CNT_HI: next_s.rdata = s.count[15:8];
        PWP_OFS_PER1_LO: next_s.rdata = s.first_period[7:0];
        PWP_OFS_PER1_HI: next_s.rdata = s.first_period[15:8];
        PWP_OFS_DUTY1_LO: next_s.rdata = s.first_duty[7:0];
        PWP_OFS_DUTY1_HI: next_s.rdata = s.first_duty[15:8];
        PWP_OFS_PER2_LO: next_s.rdata = s.second_period[7:0];
        PWP_OFS_PER2_HI: next_s.rdata = s.second_period[15:8];
        PWP_OFS_DUTY2_LO: next_s.rdata = s.second_duty[7:0];
        PWP_OFS_DUTY2_HI: next_s.rdata = s.second_duty[15:8];
        PWP_OFS_CTL0_FIRST: next_s.rdata = s.first_control_zero;
        PWP_OFS_CTL1_FIRST: begin
          next_s.rdata[PWP_C1_RUN_BIT] = s.run_request_bit;
          next_s.rdata[PWP_C1_STAT_BIT] = s.running_status_bit;
          next_s.rdata[PWP_C1_ONESHOT_BIT] = s.one_shot_select;
          next_s.rdata[PWP_C1_PAIR_BIT] = s.pair_cooperation_enable;
          next_s.rdata[PWP_C1_DT_BIT] = s.dead_time_enable;
        end
        PWP_OFS_CTL2_FIRST: next_s.rdata = s.first_control_two;
        PWP_OFS_CTL0_SECOND: next_s.rdata = s.second_control_zero;
        default: next_s.rdata = 8'h00;
      endcase
    end

    // pins follow the flags through their polarity, registered in the same cycle as the flags
    next_s.out_first = next_s.first_output_flag ^
                       next_s.first_control_zero[PWP_C0_POL_BIT];
    next_s.out_second = next_s.second_output_flag ^
                        next_s.second_control_zero[PWP_C0S_POL_BIT];
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
      s.count <= PWP_RST_COUNT;
      s.first_period <= PWP_RST_PERIOD;
      s.second_period <= PWP_RST_PERIOD;
      s.first_duty <= PWP_RST_DUTY;
      s.second_duty <= PWP_RST_DUTY;
      s.first_period_buffer <= PWP_RST_PERIOD;
      s.second_period_buffer <= PWP_RST_PERIOD;
      s.first_duty_buffer <= PWP_RST_DUTY;
      s.second_duty_buffer <= PWP_RST_DUTY;
      s.first_control_zero <= PWP_RST_CTL;
      s.first_control_two <= PWP_RST_CTL;
      s.second_control_zero <= PWP_RST_CTL;
      s.first_output_flag <= 1'b1;
      s.second_output_flag <= 1'b1;
      s.out_first <= 1'b1;
      s.out_second <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rdata_o = s.rdata;
  assign first_pwm_output_o = s.out_first;
  assign second_pwm_output_o = s.out_second;
  assign pwm_event_o = s.event_pulse;

endmodule

// ---- pwp_pair_pwm_monitor.sv ----
`timescale 1ns/1ps
module pwp_pair_monitor
  import pwp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [PWP_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic trigger_a_i,
  input wire logic trigger_b_i,
  input wire logic [7:0] rdata_o,
  input wire logic first_pwm_output_o,
  input wire logic second_pwm_output_o,
  input wire logic pwm_event_o
);
  // ----------------------------------------
  // shadow of software-written control bits
  // ----------------------------------------
  typedef struct packed {
    logic pol1;
    logic pol2;
    logic run;
    logic [1:0] mode;
    logic [4:0] idle;
  } pwp_shadow_type;
  pwp_shadow_type sh;
  pwp_shadow_type next_sh;

  // idle counts cycles with run and external control both off; saturates
  always_comb begin
    next_sh = sh;
    if (wr_i && addr_i == PWP_OFS_CTL0_FIRST) next_sh.pol1 = wdata_i[PWP_C0_POL_BIT];
    if (wr_i && addr_i == PWP_OFS_CTL0_SECOND) next_sh.pol2 = wdata_i[PWP_C0S_POL_BIT];
    if (wr_i && addr_i == PWP_OFS_CTL1_FIRST) next_sh.run = wdata_i[PWP_C1_RUN_BIT];
    if (wr_i && addr_i == PWP_OFS_CTL2_FIRST) next_sh.mode = wdata_i[1:0];
    if (sh.run || sh.mode != PWP_EXT_OFF) next_sh.idle = 5'h00;
    else if (sh.idle != 5'h1F) next_sh.idle = sh.idle + 5'h01;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) sh <= '0;
    else sh <= next_sh;
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside its slot");
  a_unmapped_read: assert property (rd_i && addr_i >= 4'hE |=> rdata_o == 8'h00)
    else $error("unmapped read returned data");
  a_event_single: assert property (pwm_event_o |=> !pwm_event_o)
    else $error("event pulse longer than one cycle");
  a_cnt_clear: assert property (
    wr_i && addr_i[3:1] == 3'h0 |=> first_pwm_output_o == !sh.pol1)
    else $error("counter write did not raise first output");
  a_pol_first: assert property (
    sh.idle == 5'h1F && wr_i && addr_i == PWP_OFS_CTL0_FIRST
    && wdata_i[PWP_C0_POL_BIT] != sh.pol1
    |=> first_pwm_output_o != $past(first_pwm_output_o))
    else $error("first polarity change not seen");
  a_pol_second: assert property (
    sh.idle == 5'h1F && wr_i && addr_i == PWP_OFS_CTL0_SECOND
    && wdata_i[PWP_C0S_POL_BIT] != sh.pol2
    |=> second_pwm_output_o != $past(second_pwm_output_o))
    else $error("second polarity change not seen");
  a_halt_quiet: assert property (
    sh.idle == 5'h1F && !$past(wr_i) |-> !pwm_event_o && $stable(first_pwm_output_o))
    else $error("activity while halted");
  a_reset_out: assert property (
    $rose(rst_b_i) |-> first_pwm_output_o && second_pwm_output_o && !pwm_event_o)
    else $error("outputs wrong after reset");

  c_event: cover property (pwm_event_o);
  c_cnt_write: cover property (wr_i && addr_i[3:1] == 3'h0);
  c_pol_flip: cover property (sh.idle == 5'h1F && wr_i && addr_i == PWP_OFS_CTL0_SECOND);
endmodule

bind pwp_pair_pwm pwp_pair_monitor i_mon (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .trigger_a_i(trigger_a_i),
  .trigger_b_i(trigger_b_i), .rdata_o(rdata_o), .first_pwm_output_o(first_pwm_output_o),
  .second_pwm_output_o(second_pwm_output_o), .pwm_event_o(pwm_event_o));

// ---- pwp_far_model.sv ----
`timescale 1ns/1ps
module pwp_far_model (
  input wire logic mclk_i,
  output logic trigger_a_o,
  output logic trigger_b_o
);
  // both trigger pins idle low; only the chosen pin moves
  initial begin
    trigger_a_o = 1'b0;
    trigger_b_o = 1'b0;
  end

  // level changes just after an edge, held until the next call
  task automatic drive(input logic pin, input logic lvl);
    @(posedge mclk_i);
    if (pin) trigger_b_o <= lvl;
    else trigger_a_o <= lvl;
    repeat (3) @(posedge mclk_i);
  endtask
endmodule

// ---- pwm_pair_cooperation_tb_top.sv ----
`timescale 1ns/1ps
module pwm_pair_cooperation_tb_top;
  import pwp_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic trig_a;
  logic trig_b;
  logic [7:0] rdata;
  logic out1;
  logic out2;
  logic ev;
  int n_fail = 0;
  int comparisons = 0;

  always #2 mclk = ~mclk;

  pwp_pair_pwm i_dut (.mclk_i(mclk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .trigger_a_i(trig_a), .trigger_b_i(trig_b), .rdata_o(rdata),
    .first_pwm_output_o(out1), .second_pwm_output_o(out2), .pwm_event_o(ev));
  pwp_far_model i_far (.mclk_i(mclk), .trigger_a_o(trig_a), .trigger_b_o(trig_b));

  // ----------------------------------------
  // bus and judging helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr8(a, d[7:0]);
    wr8(a + 4'h1, d[15:8]);
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask

  task automatic poll(input logic want);
    logic [7:0] d;
    for (int i = 0; i < 40; i++) begin
      rd8(PWP_OFS_CTL1_FIRST, d);
      if (d[PWP_C1_STAT_BIT] === want) break;
    end
    check(d[PWP_C1_STAT_BIT], want);
  endtask

  // one full period from event to event; low cycles of each output inside it
  task automatic meas(output int gap, output int l1, output int l2);
    int i;
    i = 0;
    gap = 0;
    l1 = 0;
    l2 = 0;
    do begin @(posedge mclk); i++; end while (ev !== 1'b1 && i < 300);
    do begin
      @(posedge mclk);
      gap++;
      l1 += (out1 === 1'b0);
      l2 += (out2 === 1'b0);
    end while (ev !== 1'b1 && gap < 300);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_pol;
    logic [7:0] d;
    // let the block sit idle long enough for the halted-state checks to arm
    repeat (32) @(posedge mclk);
    rd8(PWP_OFS_CTL1_FIRST, d);
    check(d, 8'h00);
    rd8(PWP_OFS_PER1_HI, d);
    check(d, 8'h0F);
    rd8(4'hF, d);
    check(d, 8'h00);
    check({out2, out1}, 2'h3);
    wr8(PWP_OFS_CTL0_FIRST, 8'h10);
    @(posedge mclk);
    check(out1, 1'b0);
    wr8(PWP_OFS_CTL0_SECOND, 8'h01);
    @(posedge mclk);
    check(out2, 1'b0);
    wr8(PWP_OFS_CTL0_FIRST, 8'h00);
    wr8(PWP_OFS_CTL0_SECOND, 8'h00);
  endtask

  // written while stopped, so the buffers take the values at once
  task automatic t_repeat;
    int g, l1, l2;
    wr16(PWP_OFS_PER1_LO, 16'h0005);
    wr16(PWP_OFS_DUTY1_LO, 16'h0001);
    wr16(PWP_OFS_PER2_LO, 16'h0004);
    wr16(PWP_OFS_DUTY2_LO, 16'h0002);
    wr8(PWP_OFS_CTL1_FIRST, 8'h09);
    for (int k = 0; k < 2; k++) begin
      meas(g, l1, l2);
      check(16'(g), 16'd6);
      check(16'(l1), 16'd4);
      check(16'(l2), 16'd2);
    end
  endtask

  // new values only take effect from the next period match
  task automatic t_reload;
    int g, l1, l2;
    wr16(PWP_OFS_PER1_LO, 16'h0003);
    wr16(PWP_OFS_DUTY1_LO, 16'h0000);
    meas(g, l1, l2);
    meas(g, l1, l2);
    check(16'(g), 16'd4);
    check(16'(l1), 16'd3);
  endtask

  task automatic t_stop_clear;
    logic [7:0] v1, v2, v3;
    wr8(PWP_OFS_CTL1_FIRST, 8'h08);
    poll(1'b0);
    wr16(PWP_OFS_PER1_LO, 16'h0FFF);
    wr8(PWP_OFS_CTL1_FIRST, 8'h09);
    repeat (40) @(posedge mclk);
    wr8(PWP_OFS_CTL1_FIRST, 8'h08);
    poll(1'b0);
    rd8(PWP_OFS_CNT_LO, v1);
    repeat (5) @(posedge mclk);
    rd8(PWP_OFS_CNT_LO, v2);
    check(v2, v1);
    wr8(PWP_OFS_CTL1_FIRST, 8'h09);
    poll(1'b1);
    rd8(PWP_OFS_CNT_LO, v3);
    check(v3 > v1 && v3 <= v1 + 8, 1'b1);
    wr8(PWP_OFS_CTL1_FIRST, 8'h08);
    poll(1'b0);
    check(out1, 1'b0);
    wr8(PWP_OFS_CNT_HI, 8'h5A);
    rd8(PWP_OFS_CNT_LO, v1);
    rd8(PWP_OFS_CNT_HI, v2);
    check({v2, v1}, 16'h0000);
    check(out1, 1'b1);
  endtask

  task automatic t_oneshot;
    logic [7:0] d;
    int n;
    wr16(PWP_OFS_PER1_LO, 16'h0003);
    for (int k = 0; k < 2; k++) begin
      wr8(PWP_OFS_CTL1_FIRST, 8'h0D);
      n = 0;
      do begin @(posedge mclk); n++; end while (ev !== 1'b1 && n < 100);
      // start tick, four counting ticks, then one cycle for the registered event
      check(16'(n), 16'd6);
    end
    poll(1'b0);
    rd8(PWP_OFS_CTL1_FIRST, d);
    check(d[PWP_C1_RUN_BIT], 1'b0);
    rd8(PWP_OFS_CNT_LO, d);
    check(d, 8'h00);
    n = 0;
    repeat (20) begin @(posedge mclk); n += (ev === 1'b1); end
    check(16'(n), 16'd0);
  endtask

  // tick every second clock, dead time taken from the second duty, event at first fall
  task automatic t_divide_dead;
    int g, l1, l2;
    wr8(PWP_OFS_CTL0_FIRST, 8'h09);
    wr16(PWP_OFS_PER1_LO, 16'h0007);
    wr16(PWP_OFS_DUTY1_LO, 16'h0002);
    wr16(PWP_OFS_DUTY2_LO, 16'h0001);
    wr8(PWP_OFS_CTL1_FIRST, 8'h19);
    meas(g, l1, l2);
    meas(g, l1, l2);
    check(16'(g), 16'd16);
    check(16'(l1), 16'd8);
    check(16'(l2), 16'd2);
    check(out1, 1'b0);
    wr8(PWP_OFS_CTL1_FIRST, 8'h18);
    poll(1'b0);
    wr8(PWP_OFS_CTL0_FIRST, 8'h00);
  endtask

  task automatic t_trigger;
    logic [7:0] d;
    wr8(PWP_OFS_CTL2_FIRST, 8'h01);
    i_far.drive(1'b0, 1'b1);
    poll(1'b1);
    i_far.drive(1'b0, 1'b0);
    wr8(PWP_OFS_CTL2_FIRST, 8'h16);
    i_far.drive(1'b1, 1'b1);
    rd8(PWP_OFS_CTL1_FIRST, d);
    check(d[PWP_C1_STAT_BIT], 1'b1);
    i_far.drive(1'b1, 1'b0);
    poll(1'b0);
    // clear mode on a high level of pin A: counter held at zero, both flags high
    wr8(PWP_OFS_CTL2_FIRST, 8'h0F);
    i_far.drive(1'b0, 1'b1);
    rd8(PWP_OFS_CNT_LO, d);
    check(d, 8'h00);
    check({out2, out1}, 2'h3);
    i_far.drive(1'b0, 1'b0);
    poll(1'b1);
    wr8(PWP_OFS_CTL1_FIRST, 8'h18);
    poll(1'b0);
    wr8(PWP_OFS_CTL2_FIRST, 8'h00);
  endtask

  // run length is a few hundred cycles; this bound of 15000 cycles is dozens of times that
  initial begin
    #60000;
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset_pol();
    t_repeat();
    t_reload();
    t_stop_clear();
    t_oneshot();
    t_divide_dead();
    t_trigger();
    stop_test();
  end
endmodule
